// ### rtl/npx_unit_regs.vh
// Purpose: register indices, field positions, reset values and constants
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef NPX_UNIT_REGS_VH
`define NPX_UNIT_REGS_VH

// register indices (byte address = index * 4)
`define NPX_IDX_CENTRAL   8'hE6
`define NPX_IDX_EDGE      8'hF2
`define NPX_IDX_PEND      8'hF3
`define NPX_IDX_MASK      8'hF4
`define NPX_IDX_PAIR      8'hF5
`define NPX_IDX_NEST      8'hF7
`define NPX_IDX_OPTION    8'hF8
`define NPX_IDX_CODESEG   8'hF9
`define NPX_IDX_HANDSEG   8'hFA
`define NPX_IDX_VECBASE   8'hFB
`define NPX_ADDR(idx)     ({(idx), 2'b00})

// central control fields
`define NPX_CC_SPARE      7
`define NPX_CC_GME        4
`define NPX_CC_ARB        3
`define NPX_CC_CPL_HI     2
`define NPX_CC_RESET      8'h87

// option register fields
`define NPX_OP_A0SEL      0
`define NPX_OP_C0SEL      1
`define NPX_OP_D0SEL      2
`define NPX_OP_SEGSAVE    4
`define NPX_OP_RESET      8'h03

// other reset values
`define NPX_BYTE_RESET    8'h00
`define NPX_LOWEST_PRIO   3'h7
`define NPX_NO_LEVEL      4'h8
`define NPX_VEC_FIELD     4

`endif

// ### rtl/npx_unit.v
// Purpose: nested/concurrent interrupt sequencing and eight external channels
// Assumes: core pops with data valid while stk_pop is high; APB, zero wait
// Notes:   top-level interrupt is handled elsewhere and never enters here
// Behaviour
// - nested ack sets nesting bit at level
// - nested ack loads level with request priority
// - entry: disable, save level, push, vector
// - entry loads or substitutes handler segment
// - return pops flags, segment, pc, enables
// - nested return restores level from stack
// - return resumes code segment unless nested
// - no re-enable gives priority-ordered service
// - concurrent re-enable lets lower levels preempt
// - eight pins map onto four channel pairs
// - edge select: one rising, zero falling
// - per-channel mask, A0 bit7 to D1 bit0
// - pair priority bits, odd channel one lower
// - A0 from pin zero or timer
// - B0 from pin two only when serial off
// - C0 from pin four or standard timer
// - D0 from pin six or clock control
// - acknowledge only if priority below level
// - current level resets to seven
// - one bit selects concurrent or nested
// - top-level entry never touches these fields
`include "npx_unit_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module npx_unit (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [9:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// external pins and peripheral requesters
	input  wire [7:0]  ext_pin,
	input  wire        timer_wdog_irq,
	input  wire        serial_irq,
	input  wire        serial_periph_on,
	input  wire        serial_periph_mode,
	input  wire        standard_timer_irq,
	input  wire        clock_control_irq,
	// core request and acknowledge
	output reg         irq_request,
	output reg  [2:0]  irq_priority,
	input  wire        core_take,
	input  wire        core_iret,
	input  wire [15:0] core_pc,
	input  wire [7:0]  core_flags,
	output reg         seq_busy,
	// system stack
	output reg         stk_push,
	output reg  [7:0]  stk_wdata,
	output reg         stk_pop,
	input  wire [7:0]  stk_rdata,
	// vector fetch
	output reg         vec_req,
	output reg  [7:0]  vec_addr,
	input  wire        vec_valid,
	input  wire [15:0] vec_data,
	// core state reload
	output reg         pc_load,
	output reg  [15:0] pc_out,
	output reg         flags_load,
	output reg  [7:0]  flags_out,
	output reg  [7:0]  active_segment
);

	localparam [9:0] S_IDLE = 10'h001;
	localparam [9:0] S_PCL  = 10'h002;
	localparam [9:0] S_PCH  = 10'h004;
	localparam [9:0] S_CSP  = 10'h008;
	localparam [9:0] S_FLG  = 10'h010;
	localparam [9:0] S_VEC  = 10'h020;
	localparam [9:0] S_RFL  = 10'h040;
	localparam [9:0] S_RCS  = 10'h080;
	localparam [9:0] S_RPH  = 10'h100;
	localparam [9:0] S_RPL  = 10'h200;

	reg  [9:0]  state;
	reg  [7:0]  central;
	reg  [7:0]  ext_edge_select;
	reg  [7:0]  ext_pending_flags;
	reg  [7:0]  ext_mask_bits;
	reg  [7:0]  ext_pair_priority;
	reg  [7:0]  nesting_level_stack;
	reg  [7:0]  option;
	reg  [7:0]  code_segment_reg;
	reg  [7:0]  handler_segment_reg;
	reg  [3:0]  vector_index;
	reg  [7:0]  pin_meta;
	reg  [7:0]  pin_sync;
	reg  [7:0]  src_prev;
	reg  [3:0]  depth;
	reg         use_handler_seg;
	reg  [2:0]  taken_ch;
	reg  [15:0] saved_pc;
	reg  [7:0]  saved_flags;
	reg  [7:0]  pc_hi;
	reg  [7:0]  rd_value;
	reg         rd_hit;
	reg  [3:0]  best_lvl;
	reg  [2:0]  best_ch;
	reg  [2:0]  restore_lvl;
	reg         restore_found;
	reg  [7:0]  take_clear;
	integer     i;

	wire [7:0]  src;
	wire [7:0]  trig;
	wire [23:0] lvl_flat;
	wire [2:0]  current_priority  = central[`NPX_CC_CPL_HI:0];
	wire        global_mask_enable = central[`NPX_CC_GME];
	wire        arbitration_select = central[`NPX_CC_ARB];
	wire        segment_save_option = option[`NPX_OP_SEGSAVE];
	wire        wr_en = psel & penable & pready & pwrite & ~pslverr;
	wire        setup = psel & ~penable;
	wire        win_valid = (best_lvl < {1'b0, current_priority});
	wire        take = core_take & irq_request & win_valid & (state == S_IDLE);
	wire        ret = core_iret & (state == S_IDLE) & (depth != 4'h0);

	// pins cross into pclk through two flops; peripherals share the clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= `NPX_BYTE_RESET;
			pin_sync <= `NPX_BYTE_RESET;
		end else begin
			pin_meta <= ext_pin;
			pin_sync <= pin_meta;
		end
	end

	assign src[0] = option[`NPX_OP_A0SEL] ? pin_sync[0] : timer_wdog_irq;
	assign src[1] = pin_sync[1];
	assign src[2] = (~serial_periph_on & ~serial_periph_mode) ? pin_sync[2] : serial_irq;
	assign src[3] = pin_sync[3];
	assign src[4] = option[`NPX_OP_C0SEL] ? pin_sync[4] : standard_timer_irq;
	assign src[5] = pin_sync[5];
	assign src[6] = option[`NPX_OP_D0SEL] ? clock_control_irq : pin_sync[6];
	assign src[7] = pin_sync[7];

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : chan
			assign trig[g] = ext_edge_select[g] ? (src[g] & ~src_prev[g])
			                                     : (~src[g] & src_prev[g]);
			assign lvl_flat[3*g+2:3*g] = {ext_pair_priority[7-2*(g/2)],
			                              ext_pair_priority[6-2*(g/2)], g % 2 == 1};
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev <= `NPX_BYTE_RESET;
		end else begin
			src_prev <= src;
		end
	end

	// priority search; lowest channel index wins a tie like the daisy chain
	always @* begin
		best_lvl = `NPX_NO_LEVEL;
		best_ch = 3'h0;
		for (i = 7; i >= 0; i = i - 1) begin
			if (ext_pending_flags[i] && ext_mask_bits[7-i] &&
			    ({1'b0, lvl_flat[3*i+2 -: 3]} <= best_lvl)) begin
				best_lvl = {1'b0, lvl_flat[3*i+2 -: 3]};
				best_ch = i[2:0];
			end
		end
	end

	always @* begin
		restore_lvl = `NPX_LOWEST_PRIO;
		restore_found = 1'b0;
		for (i = 7; i >= 0; i = i - 1) begin
			if (nesting_level_stack[i]) begin
				restore_lvl = i[2:0];
				restore_found = 1'b1;
			end
		end
	end

	always @* begin
		take_clear = 8'h00;
		if (take) begin
			take_clear[best_ch] = 1'b1;
		end
	end

	// pending: a new edge beats both a software clear and the ack clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_pending_flags <= `NPX_BYTE_RESET;
		end else if (wr_en && paddr == `NPX_ADDR(`NPX_IDX_PEND)) begin
			ext_pending_flags <= (pwdata[7:0] & ~take_clear) | trig;
		end else begin
			ext_pending_flags <= (ext_pending_flags & ~take_clear) | trig;
		end
	end

	// read mux, prepared in the setup phase so prdata is a flop
	always @* begin
		rd_hit = 1'b1;
		rd_value = 8'h00;
		if (paddr == `NPX_ADDR(`NPX_IDX_CENTRAL)) begin
			rd_value = {central[7], 2'b00, central[4:0]};
		end else if (paddr == `NPX_ADDR(`NPX_IDX_EDGE)) begin
			rd_value = ext_edge_select;
		end else if (paddr == `NPX_ADDR(`NPX_IDX_PEND)) begin
			rd_value = ext_pending_flags;
		end else if (paddr == `NPX_ADDR(`NPX_IDX_MASK)) begin
			rd_value = ext_mask_bits;
		end else if (paddr == `NPX_ADDR(`NPX_IDX_PAIR)) begin
			rd_value = ext_pair_priority;
		end else if (paddr == `NPX_ADDR(`NPX_IDX_NEST)) begin
			rd_value = nesting_level_stack;
		end else if (paddr == `NPX_ADDR(`NPX_IDX_OPTION)) begin
			rd_value = option;
		end else if (paddr == `NPX_ADDR(`NPX_IDX_CODESEG)) begin
			rd_value = code_segment_reg;
		end else if (paddr == `NPX_ADDR(`NPX_IDX_HANDSEG)) begin
			rd_value = handler_segment_reg;
		end else if (paddr == `NPX_ADDR(`NPX_IDX_VECBASE)) begin
			rd_value = {vector_index, 4'h0};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~rd_hit;
			if (setup) begin
				prdata <= {24'h000000, rd_value};
			end
		end
	end

	// plain software registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_edge_select <= `NPX_BYTE_RESET;
			ext_mask_bits <= `NPX_BYTE_RESET;
			ext_pair_priority <= `NPX_BYTE_RESET;
			option <= `NPX_OP_RESET;
			handler_segment_reg <= `NPX_BYTE_RESET;
			vector_index <= 4'h0;
		end else if (wr_en) begin
			if (paddr == `NPX_ADDR(`NPX_IDX_EDGE)) begin
				ext_edge_select <= pwdata[7:0];
			end else if (paddr == `NPX_ADDR(`NPX_IDX_MASK)) begin
				ext_mask_bits <= pwdata[7:0];
			end else if (paddr == `NPX_ADDR(`NPX_IDX_PAIR)) begin
				ext_pair_priority <= pwdata[7:0];
			end else if (paddr == `NPX_ADDR(`NPX_IDX_OPTION)) begin
				option <= pwdata[7:0] & 8'h17;
			end else if (paddr == `NPX_ADDR(`NPX_IDX_HANDSEG)) begin
				handler_segment_reg <= pwdata[7:0];
			end else if (paddr == `NPX_ADDR(`NPX_IDX_VECBASE)) begin
				vector_index <= pwdata[7:`NPX_VEC_FIELD];
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_request <= 1'b0;
			irq_priority <= `NPX_LOWEST_PRIO;
			seq_busy <= 1'b0;
			active_segment <= `NPX_BYTE_RESET;
		end else begin
			irq_request <= win_valid & global_mask_enable & (state == S_IDLE) & ~take;
			irq_priority <= best_lvl[2:0];
			seq_busy <= (state != S_IDLE) | take | ret;
			active_segment <= use_handler_seg ? handler_segment_reg : code_segment_reg;
		end
	end

	// sequencer; its updates follow software writes so hardware wins a collision
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			central <= `NPX_CC_RESET;
			nesting_level_stack <= `NPX_BYTE_RESET;
			code_segment_reg <= `NPX_BYTE_RESET;
			depth <= 4'h0;
			use_handler_seg <= 1'b0;
			taken_ch <= 3'h0;
			saved_pc <= 16'h0000;
			saved_flags <= `NPX_BYTE_RESET;
			pc_hi <= `NPX_BYTE_RESET;
			stk_push <= 1'b0;
			stk_wdata <= `NPX_BYTE_RESET;
			stk_pop <= 1'b0;
			vec_req <= 1'b0;
			vec_addr <= `NPX_BYTE_RESET;
			pc_load <= 1'b0;
			pc_out <= 16'h0000;
			flags_load <= 1'b0;
			flags_out <= `NPX_BYTE_RESET;
		end else begin
			pc_load <= 1'b0;
			flags_load <= 1'b0;
			if (wr_en && paddr == `NPX_ADDR(`NPX_IDX_CENTRAL)) begin
				central <= pwdata[7:0] & 8'h9F;
			end else if (wr_en && paddr == `NPX_ADDR(`NPX_IDX_NEST)) begin
				nesting_level_stack <= pwdata[7:0];
			end else if (wr_en && paddr == `NPX_ADDR(`NPX_IDX_CODESEG)) begin
				code_segment_reg <= pwdata[7:0];
			end
			case (state)
			S_IDLE: begin
				if (take) begin
					central[`NPX_CC_GME] <= 1'b0;
					if (arbitration_select) begin
						nesting_level_stack[current_priority] <= 1'b1;
						central[`NPX_CC_CPL_HI:0] <= best_lvl[2:0];
					end
					taken_ch <= best_ch;
					saved_pc <= core_pc;
					saved_flags <= core_flags;
					stk_push <= 1'b1;
					stk_wdata <= core_pc[7:0];
					state <= S_PCL;
				end else if (ret) begin
					stk_pop <= 1'b1;
					state <= S_RFL;
				end
			end
			S_PCL: begin
				stk_wdata <= saved_pc[15:8];
				state <= S_PCH;
			end
			S_PCH: begin
				if (segment_save_option) begin
					stk_wdata <= code_segment_reg;
					state <= S_CSP;
				end else begin
					stk_wdata <= saved_flags;
					state <= S_FLG;
				end
			end
			S_CSP: begin
				stk_wdata <= saved_flags;
				state <= S_FLG;
			end
			S_FLG: begin
				stk_push <= 1'b0;
				vec_req <= 1'b1;
				vec_addr <= {vector_index, taken_ch, 1'b0};
				state <= S_VEC;
			end
			S_VEC: begin
				if (vec_valid) begin
					vec_req <= 1'b0;
					pc_out <= vec_data;
					pc_load <= 1'b1;
					if (segment_save_option) begin
						code_segment_reg <= handler_segment_reg;
						use_handler_seg <= 1'b0;
					end else begin
						use_handler_seg <= 1'b1;
					end
					depth <= depth + 4'h1;
					state <= S_IDLE;
				end
			end
			S_RFL: begin
				flags_out <= stk_rdata;
				flags_load <= 1'b1;
				state <= segment_save_option ? S_RCS : S_RPH;
			end
			S_RCS: begin
				code_segment_reg <= stk_rdata;
				state <= S_RPH;
			end
			S_RPH: begin
				pc_hi <= stk_rdata;
				state <= S_RPL;
			end
			S_RPL: begin
				stk_pop <= 1'b0;
				pc_out <= {pc_hi, stk_rdata};
				pc_load <= 1'b1;
				central[`NPX_CC_GME] <= 1'b1;
				if (arbitration_select) begin
					central[`NPX_CC_CPL_HI:0] <= restore_lvl;
					if (restore_found) begin
						nesting_level_stack[restore_lvl] <= 1'b0;
					end
				end
				// back to code segment unless nested
				use_handler_seg <= ~segment_save_option & arbitration_select &
				                   (depth != 4'h1);
				depth <= depth - 4'h1;
				state <= S_IDLE;
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// ### tb/npx_unit_asserts.sv
// Purpose: port-level checker for the interrupt sequencer
// Assumes: one clock domain, presetn asynchronous active low
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module npx_unit_asserts (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// apb
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	// core side
	input wire logic       irq_request,
	input wire logic [2:0] irq_priority,
	input wire logic       core_take,
	input wire logic       seq_busy,
	input wire logic       stk_push,
	input wire logic       stk_pop,
	input wire logic       vec_req,
	input wire logic       vec_valid,
	input wire logic       pc_load,
	input wire logic       flags_load
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("apb answer late");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_entry_push: assert property (core_take && irq_request && !seq_busy |=> stk_push && seq_busy)
		else $error("entry did not start pushing");
	chk_push_frame: assert property ($rose(stk_push) |-> stk_push [*3])
		else $error("entry frame too short");
	chk_vec_follow: assert property ($fell(stk_push) |-> vec_req)
		else $error("vector fetch missing after pushes");
	chk_vec_hold: assert property (vec_req && !vec_valid |=> vec_req)
		else $error("vector request dropped early");
	chk_pc_pulse: assert property (pc_load |=> !pc_load)
		else $error("pc load not a pulse");
	chk_prio_floor: assert property (irq_request |-> irq_priority != 3'h7)
		else $error("level seven request raised");
	chk_pop_flags: assert property ($rose(stk_pop) |=> flags_load)
		else $error("flags not popped first");

	cover property ($rose(pc_load));
	cover property (pslverr);
	cover property ($rose(stk_pop));
endmodule
`default_nettype wire

// ### tb/npx_core_model.sv
// Purpose: behavioural core stack and vector table
// Assumes: push and pop never in the same cycle
// Notes:   vector word is a fixed pattern over the vector address
`timescale 1ns/1ps
`default_nettype none
module npx_core_model #(parameter int VEC_WAIT = 2) (
	// clock
	input wire logic         pclk,
	// stack
	input wire logic         stk_push,
	input wire logic [7:0]   stk_wdata,
	input wire logic         stk_pop,
	output logic     [7:0]   stk_rdata,
	// vector fetch
	input wire logic         vec_req,
	input wire logic [7:0]   vec_addr,
	output logic             vec_valid,
	output logic     [15:0]  vec_data
);
	logic [7:0] mem [0:15];
	logic [3:0] sp = 4'h0;
	int         wait_cnt = 0;

	always @(posedge pclk) begin
		if (stk_push) begin
			mem[sp] <= stk_wdata;
			sp <= sp + 4'h1;
		end
		if (stk_pop)
			sp <= sp - 4'h1;
		wait_cnt <= (vec_req && !vec_valid) ? wait_cnt + 1 : 0;
	end
	// bus lines invert when not answering, so stale data cannot pass
	assign stk_rdata = stk_pop ? mem[sp - 4'h1] : ~mem[sp - 4'h1];
	assign vec_valid = vec_req && (wait_cnt >= VEC_WAIT);
	assign vec_data  = vec_valid ? {8'hC3, vec_addr} : ~{8'hC3, vec_addr};
endmodule
`default_nettype wire

// ### tb/npx_unit_test.sv
// Purpose: register, edge, mux, nested entry and return tests
// Assumes: zero wait apb slave, core model answers slowly
// Notes:   waits bounded by the global cycle ceiling
`timescale 1ns/1ps
`default_nettype none
`include "npx_unit_regs.vh"
module npx_unit_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [9:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic pready, pslverr, rerr, irq_request, seq_busy, stk_push, stk_pop, vec_req, vec_valid;
	logic [7:0] ext_pin = 8'h80, core_flags = 8'h3C, stk_wdata, stk_rdata, vec_addr;
	logic [7:0] flags_out, active_segment;
	logic tw_irq = 0, ser_irq = 0, sp_on = 0, sp_mode = 0, st_irq = 0, cc_irq = 0;
	logic core_take = 0, core_iret = 0, pc_load, flags_load;
	logic [15:0] core_pc = 16'hBEEF, vec_data, pc_out;
	logic [2:0] irq_priority;
	int err_total = 0, samples_checked = 0, cycles = 0;

	npx_unit npx_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_pin(ext_pin), .timer_wdog_irq(tw_irq), .serial_irq(ser_irq),
		.serial_periph_on(sp_on), .serial_periph_mode(sp_mode), .standard_timer_irq(st_irq),
		.clock_control_irq(cc_irq), .irq_request(irq_request), .irq_priority(irq_priority),
		.core_take(core_take), .core_iret(core_iret), .core_pc(core_pc),
		.core_flags(core_flags), .seq_busy(seq_busy), .stk_push(stk_push),
		.stk_wdata(stk_wdata), .stk_pop(stk_pop), .stk_rdata(stk_rdata), .vec_req(vec_req),
		.vec_addr(vec_addr), .vec_valid(vec_valid), .vec_data(vec_data), .pc_load(pc_load),
		.pc_out(pc_out), .flags_load(flags_load), .flags_out(flags_out),
		.active_segment(active_segment));
	npx_core_model #(.VEC_WAIT(3)) npx_core_model_i (.pclk(pclk), .stk_push(stk_push),
		.stk_wdata(stk_wdata), .stk_pop(stk_pop), .stk_rdata(stk_rdata), .vec_req(vec_req),
		.vec_addr(vec_addr), .vec_valid(vec_valid), .vec_data(vec_data));

	initial begin
		forever #12.5 pclk = ~pclk;
	end

	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask

	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= `NPX_ADDR(idx);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rdat, exp);
	endtask

	task settle;
		repeat (5) @(posedge pclk);
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 4000) begin
			err_total++;
			stop_test;
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(`NPX_IDX_CENTRAL, 32'h87);
		rd_chk(`NPX_IDX_OPTION, 32'h03);
		rd_chk(`NPX_IDX_EDGE, 32'h00);
		rd_chk(`NPX_IDX_PEND, 32'h00);
		rd_chk(`NPX_IDX_MASK, 32'h00);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		$display("test registers done");
		// edge select one rising on A0, zero falling on D1
		apb(1'b1, `NPX_IDX_EDGE, 32'h01);
		ext_pin <= 8'h01;
		settle;
		ext_pin <= 8'h00;
		settle;
		rd_chk(`NPX_IDX_PEND, 32'h81);
		apb(1'b1, `NPX_IDX_PEND, 32'h00);
		// D0 taken from clock control when its select is set
		apb(1'b1, `NPX_IDX_EDGE, 32'h41);
		apb(1'b1, `NPX_IDX_OPTION, 32'h07);
		cc_irq <= 1'b1;
		settle;
		rd_chk(`NPX_IDX_PEND, 32'h40);
		apb(1'b1, `NPX_IDX_OPTION, 32'h03);
		apb(1'b1, `NPX_IDX_PEND, 32'h00);
		$display("test edges done");
		// peripheral sources replace pins on A0, B0 and C0
		apb(1'b1, `NPX_IDX_EDGE, 32'h15);
		apb(1'b1, `NPX_IDX_OPTION, 32'h00);
		sp_on <= 1'b1;
		ext_pin <= 8'h15;
		settle;
		rd_chk(`NPX_IDX_PEND, 32'h00);
		tw_irq <= 1'b1;
		ser_irq <= 1'b1;
		st_irq <= 1'b1;
		settle;
		rd_chk(`NPX_IDX_PEND, 32'h15);
		apb(1'b1, `NPX_IDX_OPTION, 32'h03);
		sp_on <= 1'b0;
		tw_irq <= 1'b0;
		ser_irq <= 1'b0;
		st_irq <= 1'b0;
		ext_pin <= 8'h00;
		settle;
		apb(1'b1, `NPX_IDX_PEND, 32'h00);
		ext_pin <= 8'h04;
		settle;
		rd_chk(`NPX_IDX_PEND, 32'h04);
		ext_pin <= 8'h00;
		settle;
		apb(1'b1, `NPX_IDX_PEND, 32'h00);
		$display("test mux done");
		// nested entry at level 0 from A0, segment save off
		apb(1'b1, `NPX_IDX_CODESEG, 32'h21);
		apb(1'b1, `NPX_IDX_HANDSEG, 32'h5A);
		apb(1'b1, `NPX_IDX_PAIR, 32'h00);
		apb(1'b1, `NPX_IDX_MASK, 32'h80);
		apb(1'b1, `NPX_IDX_CENTRAL, 32'h1F);
		ext_pin <= 8'h01;
		while (irq_request !== 1'b1) @(posedge pclk);
		chk({29'h0, irq_priority}, 32'h0);
		core_take <= 1'b1;
		@(posedge pclk);
		core_take <= 1'b0;
		while (pc_load !== 1'b1) @(posedge pclk);
		chk({16'h0, pc_out}, 32'hC300);
		chk({24'h0, npx_core_model_i.mem[0]}, 32'hEF);
		chk({24'h0, npx_core_model_i.mem[1]}, 32'hBE);
		chk({24'h0, npx_core_model_i.mem[2]}, 32'h3C);
		@(posedge pclk);
		chk({24'h0, active_segment}, 32'h5A);
		rd_chk(`NPX_IDX_CENTRAL, 32'h08);
		rd_chk(`NPX_IDX_NEST, 32'h80);
		rd_chk(`NPX_IDX_PEND, 32'h00);
		$display("test entry done");
		core_iret <= 1'b1;
		@(posedge pclk);
		core_iret <= 1'b0;
		while (pc_load !== 1'b1) @(posedge pclk);
		chk({16'h0, pc_out}, 32'hBEEF);
		chk({24'h0, flags_out}, 32'h3C);
		@(posedge pclk);
		chk({24'h0, active_segment}, 32'h21);
		rd_chk(`NPX_IDX_CENTRAL, 32'h1F);
		rd_chk(`NPX_IDX_NEST, 32'h00);
		$display("test return done");
		// concurrent mode with segment save, channel C1
		apb(1'b1, `NPX_IDX_EDGE, 32'h20);
		apb(1'b1, `NPX_IDX_MASK, 32'h04);
		apb(1'b1, `NPX_IDX_PAIR, 32'h0C);
		apb(1'b1, `NPX_IDX_OPTION, 32'h13);
		apb(1'b1, `NPX_IDX_VECBASE, 32'h30);
		apb(1'b1, `NPX_IDX_CENTRAL, 32'h17);
		ext_pin <= 8'h21;
		settle;
		chk({31'h0, irq_request}, 32'h0);
		apb(1'b1, `NPX_IDX_PAIR, 32'h08);
		while (irq_request !== 1'b1) @(posedge pclk);
		chk({29'h0, irq_priority}, 32'h5);
		core_take <= 1'b1;
		@(posedge pclk);
		core_take <= 1'b0;
		while (pc_load !== 1'b1) @(posedge pclk);
		chk({16'h0, pc_out}, 32'hC33A);
		chk({24'h0, vec_addr}, 32'h3A);
		chk({24'h0, npx_core_model_i.mem[2]}, 32'h21);
		chk({24'h0, npx_core_model_i.mem[3]}, 32'h3C);
		rd_chk(`NPX_IDX_CODESEG, 32'h5A);
		rd_chk(`NPX_IDX_CENTRAL, 32'h07);
		core_iret <= 1'b1;
		@(posedge pclk);
		core_iret <= 1'b0;
		while (pc_load !== 1'b1) @(posedge pclk);
		chk({16'h0, pc_out}, 32'hBEEF);
		chk({24'h0, flags_out}, 32'h3C);
		rd_chk(`NPX_IDX_CODESEG, 32'h21);
		rd_chk(`NPX_IDX_CENTRAL, 32'h17);
		$display("test concurrent done");
		stop_test;
	end
endmodule
bind npx_unit npx_unit_asserts npx_unit_asserts_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.irq_request(irq_request), .irq_priority(irq_priority), .core_take(core_take),
	.seq_busy(seq_busy), .stk_push(stk_push), .stk_pop(stk_pop), .vec_req(vec_req),
	.vec_valid(vec_valid), .pc_load(pc_load), .flags_load(flags_load));
`default_nettype wire
